// ===== rtl/cnss_defs.svh
// constants for the node setup and status block
// Behaviour
// - the node address is tens switch times ten plus ones switch.
// - with switches at 00 or 01 the address is the one the master writes through the address object.
// - with switches at 00 and no address written the node joins as address 1.
// - with switches above 01 the switch address is used and bus writes of the address are ignored.
// - with both rate contacts off the rate comes from the bus, or 500 kBaud when none was configured.
// - both contacts on give 125 kBaud and the mixed codes give 500 and 250 kBaud, swapped by variant.
// - exactly one transmit and one receive configuration channel is offered.
// - one asynchronous transmit and one receive process data channel are enabled from reset.
// - a heartbeat is sent periodically, by default every 500 ms.
// - the fault lamp is off, single, double, triple flashing or lit for none, warning, guard, sync loss, bus-off.
// - the supply lamp is off with the supply out of range and on with it in range outside factory state.
// - the supply lamp blinks when the supply is in range and the unit is in factory state.
`ifndef CNSS_DEFS_SVH
`define CNSS_DEFS_SVH
`define CNSS_CLK_HZ 20000000
`define CNSS_HB_MS 500
`define CNSS_FLASH_MS 200
`define CNSS_DEFAULT_ADDR 7'h01
`define CNSS_BUS_ADDR_MAX 7'h01
`define CNSS_TENS_WEIGHT 7'h0a
`define CNSS_RATE_BUS 2'h0
`define CNSS_RATE_LO_ON 2'h1
`define CNSS_RATE_HI_ON 2'h2
`define CNSS_RATE_BOTH 2'h3
`define CNSS_PHASES 4'ha
`endif

// ===== rtl/cnss_pkg.sv
// types for the node setup and status block
package cnss_pkg;
  typedef enum logic [1:0] {cnss_kbd_125, cnss_kbd_250, cnss_kbd_500, cnss_kbd_1000} cnss_rate_t;
  typedef enum logic [1:0] {cnss_nmt_stopped, cnss_nmt_preop, cnss_nmt_oper, cnss_nmt_init} cnss_nmt_t;
  typedef enum logic [2:0] {cnss_err_none, cnss_err_warn, cnss_err_guard, cnss_err_sync, cnss_err_busoff}
    cnss_err_t;
endpackage

// ===== rtl/cnss_tick_if.sv
// flash phase timing shared between the sequencer and the lamp logic
`timescale 1ns/100ps
interface cnss_tick_if;
  logic phase_tick;
  logic [3:0] phase;
  modport src (output phase_tick, output phase);
  modport snk (input phase_tick, input phase);
endinterface

// ===== rtl/cnss_flash_seq.sv
// flash phase sequencer: ten phases of 200 ms form one lamp cycle
`timescale 1ns/100ps
`include "cnss_defs.svh"
module cnss_flash_seq #(
  parameter int unsigned PHASE_CYCLES = `CNSS_CLK_HZ / 1000 * `CNSS_FLASH_MS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  cnss_tick_if.src tick
);
  logic [31:0] cnt;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 32'h0;
      tick.phase_tick <= 1'b0;
    end else if (cnt >= PHASE_CYCLES - 1) begin
      cnt <= 32'h0;
      tick.phase_tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick.phase_tick <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick.phase <= 4'h0;
    end else if (tick.phase_tick) begin
      tick.phase <= (tick.phase == `CNSS_PHASES - 4'h1) ? 4'h0 : tick.phase + 4'h1;
    end
  end
endmodule

// ===== rtl/cnss_node.sv
// node setup and status: address, bit rate, channel enables, heartbeat and lamps
`timescale 1ns/100ps
`include "cnss_defs.svh"
module cnss_node #(
  parameter int unsigned HB_CYCLES = `CNSS_CLK_HZ / 1000 * `CNSS_HB_MS,
  parameter int unsigned PHASE_CYCLES = `CNSS_CLK_HZ / 1000 * `CNSS_FLASH_MS,
  parameter bit RATE_SWAP = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] addr_tens_sw,
  input wire logic [3:0] addr_ones_sw,
  input wire logic [1:0] rate_sw,
  input wire logic bus_addr_wr,
  input wire logic [6:0] bus_addr_data,
  input wire logic bus_rate_wr,
  input wire cnss_pkg::cnss_rate_t bus_rate_data,
  input wire cnss_pkg::cnss_nmt_t nmt_state,
  input wire cnss_pkg::cnss_err_t err_state,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic factory_state,
  output logic [6:0] node_addr,
  output cnss_pkg::cnss_rate_t bit_rate,
  output logic sdo_tx_en,
  output logic sdo_rx_en,
  output logic pdo_tx_en,
  output logic pdo_rx_en,
  output logic heartbeat_req,
  output logic network_state_lamp,
  output logic bus_fault_lamp,
  output logic supply_lamp
);
  import cnss_pkg::*;

  logic sampled;
  logic [6:0] sw_addr;
  logic [1:0] sw_rate;
  logic bus_addr_ok;
  logic [6:0] bus_addr;
  logic rate_cfg;
  cnss_rate_t bus_rate;
  logic [31:0] hb_cnt;
  cnss_tick_if tick();

  cnss_flash_seq #(.PHASE_CYCLES(PHASE_CYCLES)) u_seq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // lamp pattern: n flashes of one phase each, one phase apart, then dark
  function automatic logic flash_n(input logic [3:0] ph, input logic [1:0] n);
    flash_n = (ph[0] == 1'b0) && (ph < {1'b0, n, 1'b0});
  endfunction

  ////////////////////////////////////////////////////////////////
  // switch capture, once after reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampled <= 1'b0;
      sw_addr <= 7'h0;
      sw_rate <= 2'h0;
    end else if (!sampled) begin
      sampled <= 1'b1;
      // widen before the product so the tens digit cannot overflow a 4-bit intermediate
      sw_addr <= 7'(addr_tens_sw) * `CNSS_TENS_WEIGHT + 7'(addr_ones_sw);
      sw_rate <= rate_sw;
    end
  end

  // bus address is only accepted while switches sit at 00 or 01
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_addr_ok <= 1'b0;
      bus_addr <= `CNSS_DEFAULT_ADDR;
    end else if (sampled && bus_addr_wr && sw_addr <= `CNSS_BUS_ADDR_MAX) begin
      bus_addr_ok <= 1'b1;
      bus_addr <= bus_addr_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_cfg <= 1'b0;
      bus_rate <= cnss_kbd_500;
    end else if (bus_rate_wr) begin
      rate_cfg <= 1'b1;
      bus_rate <= bus_rate_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      node_addr <= `CNSS_DEFAULT_ADDR;
    end else if (sw_addr > `CNSS_BUS_ADDR_MAX) begin
      node_addr <= sw_addr;
    end else begin
      node_addr <= bus_addr_ok ? bus_addr : `CNSS_DEFAULT_ADDR;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_rate <= cnss_kbd_500;
    end else begin
      case (sw_rate)
        `CNSS_RATE_BUS: bit_rate <= rate_cfg ? bus_rate : cnss_kbd_500;
        `CNSS_RATE_LO_ON: bit_rate <= RATE_SWAP ? cnss_kbd_500 : cnss_kbd_250;
        `CNSS_RATE_HI_ON: bit_rate <= RATE_SWAP ? cnss_kbd_250 : cnss_kbd_500;
        default: bit_rate <= cnss_kbd_125;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // channels: one of each, enabled straight out of reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdo_tx_en <= 1'b1;
      sdo_rx_en <= 1'b1;
      pdo_tx_en <= 1'b1;
      pdo_rx_en <= 1'b1;
    end else begin
      sdo_tx_en <= 1'b1;
      sdo_rx_en <= 1'b1;
      pdo_tx_en <= 1'b1;
      pdo_rx_en <= 1'b1;
    end
  end

  // heartbeat pulse; counter is free-running so period never drifts
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hb_cnt <= 32'h0;
      heartbeat_req <= 1'b0;
    end else if (hb_cnt >= HB_CYCLES - 1) begin
      hb_cnt <= 32'h0;
      heartbeat_req <= 1'b1;
    end else begin
      hb_cnt <= hb_cnt + 32'h1;
      heartbeat_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // lamps
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      network_state_lamp <= 1'b0;
    end else begin
      case (nmt_state)
        cnss_nmt_stopped: network_state_lamp <= flash_n(tick.phase, 2'h1);
        cnss_nmt_preop: network_state_lamp <= ~tick.phase[0];
        cnss_nmt_oper: network_state_lamp <= 1'b1;
        default: network_state_lamp <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_fault_lamp <= 1'b0;
    end else begin
      case (err_state)
        cnss_err_none: bus_fault_lamp <= 1'b0;
        cnss_err_warn: bus_fault_lamp <= flash_n(tick.phase, 2'h1);
        cnss_err_guard: bus_fault_lamp <= flash_n(tick.phase, 2'h2);
        cnss_err_sync: bus_fault_lamp <= flash_n(tick.phase, 2'h3);
        cnss_err_busoff: bus_fault_lamp <= 1'b1;
        default: bus_fault_lamp <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_lamp <= 1'b0;
    end else if (supply_low || supply_high) begin
      supply_lamp <= 1'b0;
    end else begin
      supply_lamp <= factory_state ? ~tick.phase[0] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  chk_addr_lock: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sampled && sw_addr > `CNSS_BUS_ADDR_MAX) |=> node_addr == $past(sw_addr))
    else $error("switch address not used");
  chk_addr_default: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sw_addr <= `CNSS_BUS_ADDR_MAX && !bus_addr_ok) |=> node_addr == `CNSS_DEFAULT_ADDR)
    else $error("default address missing");
  chk_bus_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sampled && bus_addr_wr && sw_addr <= `CNSS_BUS_ADDR_MAX) |=> ##1 node_addr == $past(bus_addr_data, 2))
    else $error("bus address not taken");
  chk_sw_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    sampled |=> $stable(sw_addr) && $stable(sw_rate))
    else $error("switches resampled");
  chk_rate_both: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sampled && sw_rate == `CNSS_RATE_BOTH) |=> bit_rate == cnss_kbd_125)
    else $error("both-on rate wrong");
  chk_rate_dflt: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sampled && sw_rate == `CNSS_RATE_BUS && !rate_cfg) |=> bit_rate == cnss_kbd_500)
    else $error("default rate wrong");
  chk_pdo_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    pdo_tx_en && pdo_rx_en && sdo_tx_en && sdo_rx_en)
    else $error("channel disabled");
  sequence hb_gap_s;
    !heartbeat_req [*2];
  endsequence
  chk_hb_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
    heartbeat_req |=> hb_gap_s)
    else $error("heartbeat too frequent");
  chk_hb_count: assert property (@(posedge core_clk) disable iff (sys_rst)
    heartbeat_req |-> hb_cnt == 32'h0)
    else $error("heartbeat off period");
  chk_busoff_lit: assert property (@(posedge core_clk) disable iff (sys_rst)
    err_state == cnss_err_busoff |=> bus_fault_lamp)
    else $error("bus-off lamp not lit");
  chk_oper_lit: assert property (@(posedge core_clk) disable iff (sys_rst)
    nmt_state == cnss_nmt_oper |=> network_state_lamp)
    else $error("operational lamp not lit");
  chk_supply_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    (supply_low || supply_high) |=> !supply_lamp)
    else $error("supply lamp lit out of range");
  chk_supply_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!supply_low && !supply_high && !factory_state) |=> supply_lamp)
    else $error("supply lamp dark in range");
endmodule

// ===== sim/cnss_master_model.sv
// network master model: writes the address and bit rate objects
`timescale 1ns/100ps
module cnss_master_model (
  input wire logic core_clk,
  output logic bus_addr_wr,
  output logic [6:0] bus_addr_data,
  output logic bus_rate_wr,
  output cnss_pkg::cnss_rate_t bus_rate_data
);
  import cnss_pkg::*;
  initial begin
    bus_addr_wr = 1'b0;
    bus_addr_data = 7'h00;
    bus_rate_wr = 1'b0;
    bus_rate_data = cnss_kbd_125;
  end
  // data is inverted once the pulse ends so a stale value is never mistaken for a write
  task automatic write_addr(input logic [6:0] v);
    @(posedge core_clk);
    bus_addr_wr <= 1'b1;
    bus_addr_data <= v;
    @(posedge core_clk);
    bus_addr_wr <= 1'b0;
    bus_addr_data <= ~v;
  endtask
  task automatic write_rate(input cnss_rate_t r);
    @(posedge core_clk);
    bus_rate_wr <= 1'b1;
    bus_rate_data <= r;
    @(posedge core_clk);
    bus_rate_wr <= 1'b0;
    bus_rate_data <= cnss_rate_t'(~r);
  endtask
endmodule

// ===== sim/cnss_node_tb.sv
// self-checking bench for the node setup and status block
`timescale 1ns/100ps
module cnss_node_tb;
  import cnss_pkg::*;
  typedef struct {int sel; logic [7:0] exp;} cnss_note_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] addr_tens_sw = 4'h0;
  logic [3:0] addr_ones_sw = 4'h0;
  logic [1:0] rate_sw = 2'h0;
  logic bus_addr_wr, bus_rate_wr, heartbeat_req, supply_low = 1'b0, supply_high = 1'b0, factory_state = 1'b0;
  logic [6:0] bus_addr_data, node_addr;
  cnss_rate_t bus_rate_data, bit_rate, bit_rate_swap;
  cnss_nmt_t nmt_state = cnss_nmt_stopped;
  cnss_err_t err_state = cnss_err_none;
  logic sdo_tx_en, sdo_rx_en, pdo_tx_en, pdo_rx_en, network_state_lamp, bus_fault_lamp, supply_lamp;
  logic [7:0] cnt;
  logic [31:0] seed = 32'h7f05;
  logic [6:0] v;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int rate_exp[4] = '{2, 1, 2, 0};
  int swap_exp[4] = '{2, 2, 1, 0};
  int net_exp[3] = '{4, 20, 40};
  int err_exp[5] = '{0, 4, 8, 12, 40};
  cnss_note_t notes[$];
  event look;
  always #25 core_clk = ~core_clk;
  cnss_node #(.HB_CYCLES(20), .PHASE_CYCLES(4), .RATE_SWAP(1'b0)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .addr_tens_sw(addr_tens_sw), .addr_ones_sw(addr_ones_sw), .rate_sw(rate_sw), .bus_addr_wr(bus_addr_wr),
    .bus_addr_data(bus_addr_data), .bus_rate_wr(bus_rate_wr), .bus_rate_data(bus_rate_data),
    .nmt_state(nmt_state), .err_state(err_state), .supply_low(supply_low), .supply_high(supply_high),
    .factory_state(factory_state), .node_addr(node_addr), .bit_rate(bit_rate), .sdo_tx_en(sdo_tx_en),
    .sdo_rx_en(sdo_rx_en), .pdo_tx_en(pdo_tx_en), .pdo_rx_en(pdo_rx_en), .heartbeat_req(heartbeat_req),
    .network_state_lamp(network_state_lamp), .bus_fault_lamp(bus_fault_lamp), .supply_lamp(supply_lamp));
  cnss_master_model master_u (.core_clk(core_clk), .bus_addr_wr(bus_addr_wr), .bus_addr_data(bus_addr_data),
    .bus_rate_wr(bus_rate_wr), .bus_rate_data(bus_rate_data));
  // second hardware variant, only its bit rate is of interest
  cnss_node #(.HB_CYCLES(20), .PHASE_CYCLES(4), .RATE_SWAP(1'b1)) dut_swap_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .addr_tens_sw(addr_tens_sw), .addr_ones_sw(addr_ones_sw), .rate_sw(rate_sw),
    .bus_addr_wr(bus_addr_wr), .bus_addr_data(bus_addr_data), .bus_rate_wr(bus_rate_wr),
    .bus_rate_data(bus_rate_data), .nmt_state(nmt_state), .err_state(err_state), .supply_low(supply_low),
    .supply_high(supply_high), .factory_state(factory_state), .node_addr(), .bit_rate(bit_rate_swap),
    .sdo_tx_en(), .sdo_rx_en(), .pdo_tx_en(), .pdo_rx_en(), .heartbeat_req(), .network_state_lamp(),
    .bus_fault_lamp(), .supply_lamp());
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] pick(input int s);
    case (s)
      0: pick = {1'b0, node_addr};
      1: pick = {6'h00, bit_rate};
      2: pick = {4'h0, sdo_tx_en, sdo_rx_en, pdo_tx_en, pdo_rx_en};
      4: pick = {6'h00, bit_rate_swap};
      default: pick = cnt;
    endcase
  endfunction
  function automatic string item_name(input int s);
    case (s)
      0: item_name = "node_addr";
      1: item_name = "bit_rate";
      2: item_name = "channel_enables";
      4: item_name = "bit_rate_swapped";
      default: item_name = "lit_or_pulse_count";
    endcase
  endfunction
  task automatic check(input int s, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", item_name(s), exp, seen);
    end
  endtask
  // the watcher compares every pending note against the outputs as they stand now
  always @(look) begin
    cnss_note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(n.sel, pick(n.sel), n.exp);
    end
  end
  task automatic note(input int s, input int e);
    notes.push_back('{s, 8'(e)});
    ->look;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic reset_with(input logic [3:0] t, input logic [3:0] o, input logic [1:0] r);
    @(posedge core_clk);
    addr_tens_sw <= t;
    addr_ones_sw <= o;
    rate_sw <= r;
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    settle(3);
  endtask
  // counts lit or pulsing cycles over n cycles, a whole number of lamp cycles or heartbeat periods, so phase alignment does not matter
  task automatic count(input int which, input int n);
    settle(2);
    cnt = 8'h00;
    repeat (n) begin
      settle(1);
      case (which)
        0: cnt += 8'(network_state_lamp);
        1: cnt += 8'(bus_fault_lamp);
        2: cnt += 8'(supply_lamp);
        default: cnt += 8'(heartbeat_req);
      endcase
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 3; i >= 0; i--) begin
      reset_with(4'h0, 4'h0, 2'(i));
      note(1, rate_exp[i]);
      note(4, swap_exp[i]);
    end
    note(0, 1);
    note(2, 15);
    master_u.write_rate(cnss_kbd_250);
    settle(3);
    note(1, 1);
    reset_with(4'h0, 4'h1, 2'h0);
    seed = xs(seed);
    v = 7'(2 + seed % 90);
    master_u.write_addr(v);
    settle(3);
    note(0, v);
    reset_with(4'h4, 4'h2, 2'h0);
    note(0, 42);
    master_u.write_addr(7'h05);
    addr_tens_sw <= 4'h7;
    settle(4);
    note(0, 42);
    count(3, 100);
    note(3, 5);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      nmt_state <= cnss_nmt_t'(i);
      count(0, 40);
      note(3, net_exp[i]);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      err_state <= cnss_err_t'(i);
      count(1, 40);
      note(3, err_exp[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      supply_low <= (i == 0);
      supply_high <= (i == 1);
      factory_state <= (i == 3);
      count(2, 40);
      note(3, i < 2 ? 0 : (i == 2 ? 40 : 20));
    end
    settle(1);
    end_sim();
  end
endmodule
